// File: src/pms_top.sv
module pms_top import pms_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// wake, interrupt, reset and debug halt inputs
	input wire logic reset_pin_n,
	input wire logic cpu_irq,
	input wire logic rtc_evt,
	input wire logic sensor_evt,
	input wire logic monitor_evt,
	input wire logic debug_halt,
	// pins
	input wire logic [NPIN-1:0] pin_in,
	input wire logic [NPIN-1:0] core_out,
	input wire logic [NPIN-1:0] core_oe,
	output logic [NPIN-1:0] pad_out,
	output logic [NPIN-1:0] pad_oe,
	// power control
	output pms_gate_t gates,
	output pms_osc_t oscs,
	output logic wdt_run,
	output logic io_hold,
	output logic cpu_resume,
	output logic sys_reset,
	output logic irq
);
	pms_state_t state;
	pms_state_t next_state;
	logic [2:0] cause;
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic [2:0] wake_en;
	logic [NPIN-1:0] pin_wen;
	logic [NPIN-1:0] pin_pol;
	logic [1:0] cfg;
	logic [NPIN-1:0] pin_evt;

	// =========================================
	// mode table
	function automatic pms_gate_t gate_of(input pms_state_t s);
		pms_gate_t g;
		g = '0;
		case (s)
			ST_ACTIVE:
			begin
				g = '1;
				g.supply_duty = 1'b0;
				g.brownout_duty = 1'b0;
			end
			ST_IDLE:
			begin
				g = '1;
				g.cpu_clk = 1'b0;
				g.supply_duty = 1'b0;
				g.brownout_duty = 1'b0;
			end
			ST_STBY:
			begin
				g.sram_ret = 1'b1;
				g.supply_duty = 1'b1;
				g.medium_clk_on = 1'b1;
				g.slow_clk_on = 1'b1;
				g.sensor_on = 1'b1;
				g.aon_on = 1'b1;
				g.brownout_duty = 1'b1;
				g.por_on = 1'b1;
			end
			default: g = '0;
		endcase
		return g;
	endfunction : gate_of

	// =========================================
	// apb decode
	wire wr = psel & penable & pwrite;
	wire rd_setup = psel & ~penable & ~pwrite;
	wire hit_cmd = paddr == A_CMD;
	wire hit_stat = paddr == A_STAT;
	wire hit_cause = paddr == A_CAUSE;
	wire hit_irq = paddr == A_IRQ;
	wire hit_mask = paddr == A_MASK;
	wire hit_wake = paddr == A_WAKE;
	wire hit_pwen = paddr == A_PWEN;
	wire hit_ppol = paddr == A_PPOL;
	wire hit_cfg = paddr == A_CFG;
	wire mapped = hit_cmd | hit_stat | hit_cause | hit_irq | hit_mask |
		hit_wake | hit_pwen | hit_ppol | hit_cfg;
	wire [31:0] rdata =
		hit_stat ? {27'h0, state} :
		hit_cause ? {29'h0, cause} :
		hit_irq ? {29'h0, irq_stat} :
		hit_mask ? {29'h0, irq_mask} :
		hit_wake ? {29'h0, wake_en} :
		hit_pwen ? {24'h0, pin_wen} :
		hit_ppol ? {24'h0, pin_pol} :
		hit_cfg ? {30'h0, cfg} : 32'h0;

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// read data captured in setup so it comes from a flop in access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (rd_setup)
			prdata <= rdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_mask <= MASK_RST;
			wake_en <= WAKE_RST;
			pin_wen <= PWEN_RST;
			pin_pol <= PPOL_RST;
			cfg <= CFG_RST;
		end
		else if (wr)
		begin
			if (hit_mask)
				irq_mask <= pwdata[2:0];
			if (hit_wake)
				wake_en <= pwdata[2:0];
			if (hit_pwen)
				pin_wen <= pwdata[NPIN-1:0];
			if (hit_ppol)
				pin_pol <= pwdata[NPIN-1:0];
			if (hit_cfg)
				cfg <= pwdata[1:0];
		end
	end

	// =========================================
	// pin edges and pad latch
	pms_pin_wake u_wake
	(
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(pin_in),
		.pin_en(pin_wen),
		.pin_rise(pin_pol),
		.pin_evt(pin_evt)
	);

	pms_io_hold u_hold
	(
		.pclk(pclk),
		.presetn(presetn),
		.core_out(core_out),
		.core_oe(core_oe),
		.hold(io_hold),
		.pad_out(pad_out),
		.pad_oe(pad_oe)
	);

	// =========================================
	// interrupts
	wire pin_any = |pin_evt;
	wire [2:0] irq_set;
	wire [2:0] irq_clr = (wr & hit_irq) ? pwdata[2:0] : 3'h0;
	wire stby_wake = pin_any | (rtc_evt & wake_en[WK_RTC]) |
		(sensor_evt & wake_en[WK_SC]) | (monitor_evt & wake_en[WK_MON]);

	assign irq_set[IRQ_PIN] = pin_any;
	assign irq_set[IRQ_MON] = monitor_evt;
	assign irq_set[IRQ_WAKE] = (state == ST_STBY) & (next_state == ST_ACTIVE);

	// a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_stat <= 3'h0;
		else
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
	end

	assign irq = |(irq_stat & irq_mask);

	// =========================================
	// mode sequencer
	wire cmd_wr = wr & hit_cmd;
	wire [1:0] cmd = pwdata[1:0];

	always_comb
	begin
		next_state = state;
		case (state)
			ST_ACTIVE:
				if (cmd_wr && cmd == CMD_IDLE)
					next_state = ST_IDLE;
				else if (cmd_wr && cmd == CMD_STBY)
					next_state = ST_STBY;
				else if (cmd_wr && cmd == CMD_SHDN)
					next_state = ST_SHDN;
			ST_IDLE:
				if (cpu_irq | irq)
					next_state = ST_ACTIVE;
			ST_STBY:
				if (stby_wake)
					next_state = ST_ACTIVE;
			ST_SHDN:
				if (pin_any)
					next_state = ST_ACTIVE;
			ST_HELD:
				next_state = ST_ACTIVE;
			default:
				next_state = ST_ACTIVE;
		endcase
		if (!reset_pin_n)
			next_state = ST_HELD;
	end

	wire shdn_wake = (state == ST_SHDN) & (next_state == ST_ACTIVE);
	wire stby_resume = (state == ST_STBY) & (next_state == ST_ACTIVE);
	wire next_hold = (next_state == ST_STBY) | (next_state == ST_SHDN);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_ACTIVE;
			io_hold <= 1'b0;
			cpu_resume <= 1'b0;
			sys_reset <= 1'b0;
		end
		else
		begin
			state <= next_state;
			io_hold <= next_hold;
			cpu_resume <= stby_resume;
			sys_reset <= (next_state == ST_HELD) | shdn_wake;
		end
	end

	// power-on reset leaves the por bit set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cause <= CAUSE_RST;
		else if (next_state == ST_HELD)
			cause <= 3'h1 << CAUSE_PIN;
		else if (shdn_wake)
			cause <= 3'h1 << CAUSE_SHDN;
	end

	// =========================================
	// gates and oscillators
	assign gates = gate_of(state);
	assign oscs.fast_crystal_osc = gates.fast_clk_on & cfg[CFG_FXTAL];
	assign oscs.fast_rc_osc = gates.fast_clk_on & ~cfg[CFG_FXTAL];
	assign oscs.medium_rc_osc = gates.medium_clk_on;
	assign oscs.slow_crystal_osc = gates.slow_clk_on & cfg[CFG_SXTAL];
	assign oscs.slow_rc_osc = gates.slow_clk_on & ~cfg[CFG_SXTAL];
	// count is held, not cleared, while paused
	assign wdt_run = gates.wdt_avail & ~debug_halt;

	// =========================================
	// assertions
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_idle_gate;
		state == ST_IDLE |-> !gates.cpu_clk && gates.periph_on;
	endproperty
	a_idle_gate: assert property (p_idle_gate)
		else $error("idle clocks wrong");

	property p_idle_wake;
		state == ST_IDLE && cpu_irq && reset_pin_n |=> state == ST_ACTIVE;
	endproperty
	a_idle_wake: assert property (p_idle_wake)
		else $error("idle did not wake on interrupt");

	property p_stby_dom;
		state == ST_STBY |-> gates.aon_on && !gates.periph_on &&
			!gates.flash_on && !gates.cpu_clk && gates.sram_ret;
	endproperty
	a_stby_dom: assert property (p_stby_dom)
		else $error("standby domains wrong");

	property p_stby_stay;
		state == ST_STBY && !stby_wake && reset_pin_n |=> state == ST_STBY;
	endproperty
	a_stby_stay: assert property (p_stby_stay)
		else $error("standby left without wake");

	property p_resume;
		state == ST_STBY ##1 state == ST_ACTIVE |-> cpu_resume && !sys_reset;
	endproperty
	a_resume: assert property (p_resume)
		else $error("standby wake not a resume");

	// the entry edge itself may still load the pre-entry value
	property p_stby_hold;
		state == ST_STBY |-> io_hold ##1
			($stable(pad_out) && $stable(pad_oe));
	endproperty
	a_stby_hold: assert property (p_stby_hold)
		else $error("pins not held in standby");

	property p_shdn_off;
		state inside {ST_SHDN, ST_HELD} |-> gates == '0;
	endproperty
	a_shdn_off: assert property (p_shdn_off)
		else $error("domain on in shutdown");

	property p_shdn_freeze;
		state == ST_ACTIVE ##1 state == ST_SHDN |->
			pad_out == $past(core_out) && pad_oe == $past(core_oe);
	endproperty
	a_shdn_freeze: assert property (p_shdn_freeze)
		else $error("pins not frozen at entry");

	property p_shdn_wake;
		state == ST_SHDN && pin_any && reset_pin_n |=>
			sys_reset && cause[CAUSE_SHDN] && !cpu_resume;
	endproperty
	a_shdn_wake: assert property (p_shdn_wake)
		else $error("shutdown wake not a reset");

	property p_held;
		!reset_pin_n |=> state == ST_HELD && cause[CAUSE_PIN] && sys_reset;
	endproperty
	a_held: assert property (p_held)
		else $error("reset pin not honoured");

	property p_clocks;
		state inside {ST_STBY, ST_SHDN, ST_HELD} |-> !oscs.fast_crystal_osc &&
			!oscs.fast_rc_osc && (oscs.medium_rc_osc == (state == ST_STBY));
	endproperty
	a_clocks: assert property (p_clocks)
		else $error("clock gating wrong");

	property p_mon;
		monitor_evt |=> irq_stat[IRQ_MON];
	endproperty
	a_mon: assert property (p_mon)
		else $error("monitor event lost");

	property p_wdt;
		state == ST_STBY || debug_halt |-> !wdt_run;
	endproperty
	a_wdt: assert property (p_wdt)
		else $error("watchdog not paused");

	c_idle: cover property (state == ST_IDLE ##1 state == ST_ACTIVE);
	c_stby: cover property (state == ST_STBY ##1 state == ST_ACTIVE);
	c_shdn: cover property (state == ST_SHDN ##1 state == ST_ACTIVE);
	c_held: cover property (state == ST_HELD ##1 state == ST_ACTIVE);
endmodule : pms_top

// File: src/pms_pkg.sv
// Overview of operation
// - idle stops only the cpu clock; memories and enabled peripherals keep theirs.
// - any interrupt in idle returns the device to active.
// - standby keeps only the always-on and sensor domains alive, plus retained state.
// - standby ends only on pin, rtc, sensor controller or monitor wake, into active, or on the reset pin, into held.
// - standby wake resumes the cpu where it stopped, with no reset.
// - every pin holds its latched state throughout standby.
// - shutdown powers everything off, always-on domain and sensor too.
// - entering shutdown freezes each pin at its value just before.
// - enabled pin edge in shutdown wakes by reset, never by resume.
// - reset cause register tells pin wake, reset pin and power-on apart.
// - fast clock from crystal or rc in active and idle, else off.
// - medium clock in active, idle and standby; off in shutdown and held.
// - slow clock runs in active, idle, standby; off in shutdown and held.
// - monitor window events interrupt the cpu and can wake standby.
// - each pin is a wake and interrupt source on a chosen edge.
// - watchdog pauses, keeping count, in standby and on debug halt.
package pms_pkg;
	localparam int NPIN = 8;
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_CAUSE = 8'h08;
	localparam logic [7:0] A_IRQ = 8'h0c;
	localparam logic [7:0] A_MASK = 8'h10;
	localparam logic [7:0] A_WAKE = 8'h14;
	localparam logic [7:0] A_PWEN = 8'h18;
	localparam logic [7:0] A_PPOL = 8'h1c;
	localparam logic [7:0] A_CFG = 8'h20;
	// mode request codes written to the command register
	localparam logic [1:0] CMD_IDLE = 2'h1;
	localparam logic [1:0] CMD_STBY = 2'h2;
	localparam logic [1:0] CMD_SHDN = 2'h3;
	// reset cause bits, one-hot
	localparam int CAUSE_POR = 0;
	localparam int CAUSE_PIN = 1;
	localparam int CAUSE_SHDN = 2;
	localparam logic [2:0] CAUSE_RST = 3'h1;
	// interrupt status bits
	localparam int IRQ_PIN = 0;
	localparam int IRQ_MON = 1;
	localparam int IRQ_WAKE = 2;
	localparam logic [2:0] MASK_RST = 3'h0;
	// standby wake enable bits
	localparam int WK_RTC = 0;
	localparam int WK_SC = 1;
	localparam int WK_MON = 2;
	localparam logic [2:0] WAKE_RST = 3'h7;
	localparam logic [7:0] PWEN_RST = 8'h00;
	localparam logic [7:0] PPOL_RST = 8'hff;
	// cfg: bit0 fast clock from crystal, bit1 slow clock from crystal
	localparam int CFG_FXTAL = 0;
	localparam int CFG_SXTAL = 1;
	localparam logic [1:0] CFG_RST = 2'h0;

	typedef enum logic [4:0]
	{
		ST_ACTIVE = 5'b00001,
		ST_IDLE = 5'b00010,
		ST_STBY = 5'b00100,
		ST_SHDN = 5'b01000,
		ST_HELD = 5'b10000
	} pms_state_t;

	typedef struct packed
	{
		logic cpu_clk;
		logic flash_on;
		logic sram_on;
		logic sram_ret;
		logic supply_on;
		logic supply_duty;
		logic fast_clk_on;
		logic medium_clk_on;
		logic slow_clk_on;
		logic periph_on;
		logic sensor_on;
		logic aon_on;
		logic brownout_on;
		logic brownout_duty;
		logic por_on;
		logic wdt_avail;
	} pms_gate_t;

	typedef struct packed
	{
		logic fast_crystal_osc;
		logic fast_rc_osc;
		logic medium_rc_osc;
		logic slow_crystal_osc;
		logic slow_rc_osc;
	} pms_osc_t;
endpackage : pms_pkg

// File: src/pms_pin_wake.sv
module pms_pin_wake import pms_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pins and configuration
	input wire logic [NPIN-1:0] pin_in,
	input wire logic [NPIN-1:0] pin_en,
	input wire logic [NPIN-1:0] pin_rise,
	// per-pin edge pulses
	output logic [NPIN-1:0] pin_evt
);
	logic [NPIN-1:0] prev;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev <= '0;
		else
			prev <= pin_in;
	end

	// =========================================
	// edge select per pin
	genvar g;
	generate
		for (g = 0; g < NPIN; g++)
		begin : g_pin
			wire rise = pin_in[g] & ~prev[g];
			wire fall = ~pin_in[g] & prev[g];
			assign pin_evt[g] = pin_en[g] & (pin_rise[g] ? rise : fall);
		end
	endgenerate
endmodule : pms_pin_wake

// File: src/pms_io_hold.sv
module pms_io_hold import pms_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// from the pin mux
	input wire logic [NPIN-1:0] core_out,
	input wire logic [NPIN-1:0] core_oe,
	input wire logic hold,
	// to the pads
	output logic [NPIN-1:0] pad_out,
	output logic [NPIN-1:0] pad_oe
);
	// one cycle behind the core, so the frozen value is the pre-entry one
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pad_out <= '0;
			pad_oe <= '0;
		end
		else if (!hold)
		begin
			pad_out <= core_out;
			pad_oe <= core_oe;
		end
	end
endmodule : pms_io_hold

// File: verification/power_mode_sequencer_tb.sv
module power_mode_sequencer_tb import pms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic reset_pin_n = 1;
	logic cpu_irq = 0;
	logic rtc_evt = 0;
	logic sensor_evt = 0;
	logic monitor_evt = 0;
	logic debug_halt = 0;
	logic [NPIN-1:0] pin_in = 0;
	logic [NPIN-1:0] core_out = 0;
	logic [NPIN-1:0] core_oe = 0;
	logic [NPIN-1:0] pad_out;
	logic [NPIN-1:0] pad_oe;
	pms_gate_t gates;
	pms_osc_t oscs;
	logic wdt_run;
	logic io_hold;
	logic cpu_resume;
	logic sys_reset;
	logic irq;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int seed;
	logic [31:0] rdat;
	logic [31:0] m_irq;
	logic [7:0] v;
	logic [1:0] m_cfg;
	logic err;

	always #4 pclk = ~pclk;

	pms_top i_pms_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reset_pin_n(reset_pin_n), .cpu_irq(cpu_irq), .rtc_evt(rtc_evt),
		.sensor_evt(sensor_evt), .monitor_evt(monitor_evt),
		.debug_halt(debug_halt), .pin_in(pin_in), .core_out(core_out),
		.core_oe(core_oe), .pad_out(pad_out), .pad_oe(pad_oe),
		.gates(gates), .oscs(oscs), .wdt_run(wdt_run), .io_hold(io_hold),
		.cpu_resume(cpu_resume), .sys_reset(sys_reset), .irq(irq));

	// ==========================================
	// checking and bus tasks
	task conclude;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask : rd

	// mode 0 active, 1 idle, 2 standby, 3 shutdown, 4 reset held
	task mode_chk(input int m);
		logic [15:0] e;
		logic [4:0] o;
		e = (m == 0) ? 16'hfbfb : (m == 1) ? 16'h7bfb :
			(m == 2) ? 16'h15b6 : 16'h0;
		o = {m_cfg[0], ~m_cfg[0], 1'b1, m_cfg[1], ~m_cfg[1]};
		o = (m < 2) ? o : (m == 2) ? (o & 5'h07) : 5'h00;
		@(negedge pclk);
		chk(gates, e);
		chk(oscs, o);
		chk(wdt_run, m < 2 && !debug_halt);
		chk(io_hold, m == 2 || m == 3);
		if (m > 2)
			chk(gates, 0);
		if (m < 4)
			rd(A_STAT, 1 << m);
	endtask : mode_chk

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			conclude;
		end
	end

	// ==========================================
	// main sequence
	initial
	begin
		seed = 44;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(A_CAUSE, CAUSE_RST);
		rd(A_MASK, MASK_RST);
		rd(A_WAKE, WAKE_RST);
		rd(A_PWEN, PWEN_RST);
		rd(A_PPOL, PPOL_RST);
		rd(8'h40, 0);
		chk(err, 1'b1);
		m_cfg = $random(seed);
		apb(1'b1, A_CFG, m_cfg);
		mode_chk(0);
		debug_halt <= 1'b1;
		@(negedge pclk);
		chk(wdt_run, 1'b0);
		@(posedge pclk);
		debug_halt <= 1'b0;
		apb(1'b1, A_CMD, CMD_IDLE);
		@(posedge pclk);
		mode_chk(1);
		@(posedge pclk);
		cpu_irq <= 1'b1;
		@(posedge pclk);
		cpu_irq <= 1'b0;
		mode_chk(0);
		// ==========================================
		// standby: every wake source, pads latched
		apb(1'b1, A_PWEN, 8'h01);
		for (int k = 0; k < 4; k++)
		begin
			v = $random(seed);
			core_out <= v;
			core_oe <= ~v;
			repeat (3) @(posedge pclk);
			apb(1'b1, A_CMD, CMD_STBY);
			@(posedge pclk);
			core_out <= ~v;
			core_oe <= v;
			cpu_irq <= 1'b1;
			mode_chk(2);
			cpu_irq <= 1'b0;
			@(negedge pclk);
			chk(io_hold, 1'b1);
			chk({pad_out, pad_oe}, {v, ~v});
			@(posedge pclk);
			if (k == 3)
				pin_in[0] <= 1'b1;
			else
				{monitor_evt, sensor_evt, rtc_evt} <= 3'b001 << k;
			@(posedge pclk);
			{monitor_evt, sensor_evt, rtc_evt} <= 3'b000;
			m_irq = 32'h4 | ((k == 2) ? 32'h2 : 0) | ((k == 3) ? 32'h1 : 0);
			@(negedge pclk);
			chk({cpu_resume, sys_reset}, 2'b10);
			mode_chk(0);
			rd(A_IRQ, m_irq);
			apb(1'b1, A_IRQ, m_irq);
			rd(A_IRQ, 0);
		end
		rd(A_CAUSE, CAUSE_RST);
		// ==========================================
		// shutdown: freeze, ignored pin, reset wake
		apb(1'b1, A_PWEN, 8'h02);
		v = $random(seed);
		core_out <= v;
		core_oe <= ~v;
		repeat (3) @(posedge pclk);
		apb(1'b1, A_CMD, CMD_SHDN);
		core_out <= ~v;
		core_oe <= v;
		mode_chk(3);
		chk({pad_out, pad_oe}, {v, ~v});
		pin_in[2] <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({io_hold, sys_reset}, 2'b10);
		pin_in[1] <= 1'b1;
		@(posedge pclk);
		@(negedge pclk);
		chk({cpu_resume, sys_reset}, 2'b01);
		rd(A_CAUSE, 3'h4);
		mode_chk(0);
		apb(1'b1, A_IRQ, 32'h7);
		// ==========================================
		// interrupt mask, clear and pin polarity
		monitor_evt <= 1'b1;
		@(posedge pclk);
		monitor_evt <= 1'b0;
		@(negedge pclk);
		chk(irq, 1'b0);
		rd(A_IRQ, 32'h2);
		apb(1'b1, A_MASK, 32'h2);
		@(negedge pclk);
		chk(irq, 1'b1);
		apb(1'b1, A_IRQ, 32'h2);
		@(negedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, A_PWEN, 8'h01);
		apb(1'b1, A_PPOL, 8'hfe);
		pin_in[0] <= 1'b0;
		rd(A_IRQ, 32'h1);
		apb(1'b1, A_IRQ, 32'h1);
		pin_in[0] <= 1'b1;
		rd(A_IRQ, 32'h0);
		// other oscillator choice for the rest of the run
		m_cfg = ~m_cfg;
		apb(1'b1, A_CFG, m_cfg);
		// reset pin from every mode
		for (int k = 0; k < 4; k++)
		begin
			if (k > 0)
				apb(1'b1, A_CMD, k);
			@(posedge pclk);
			reset_pin_n <= 1'b0;
			repeat (2) @(posedge pclk);
			mode_chk(4);
			chk(sys_reset, 1'b1);
			@(posedge pclk);
			reset_pin_n <= 1'b1;
			repeat (2) @(posedge pclk);
			rd(A_CAUSE, 3'h2);
			mode_chk(0);
		end
		conclude;
	end
endmodule : power_mode_sequencer_tb
